//--- rtl/aopc_pkg.sv
/*
 * Shared constants and carrier types for the converter output port control.
 * Assumes one 25 MHz system clock and a synchronous active-low reset.
 */
package aopc_pkg;

	localparam int unsigned RES_W       = 12;
	localparam int unsigned TOP_BIT     = 11;
	localparam int unsigned FIFO_DEPTH  = 8;
	localparam int unsigned CLK_NS      = 40;
	// Conversion clock period in ns and its cycle count (rounded down, at least one).
	localparam int unsigned CONV_NS     = 1000;
	localparam int unsigned CONV_CYC    = (CONV_NS / CLK_NS) < 1 ? 1 : (CONV_NS / CLK_NS);
	localparam int unsigned HALF_CYC    = CONV_CYC / 2;
	// Pipeline stages between the held sample and the result register, each advanced once per conversion period.
	localparam int unsigned PIPE_STAGES = 2;
	localparam logic [11:0] RESULT_RST  = 12'h000;

	typedef logic [RES_W-1:0] aopc_word_t;

	typedef struct packed {
		aopc_word_t d;    // Result bits.
		logic       oe_n; // High means every result bit is released.
	} aopc_bus_t;

	typedef enum logic [0:0] {
		AOPC_SAMPLE,
		AOPC_HOLD
	} aopc_phase_t;

endpackage : aopc_pkg

//--- rtl/aopc_fifo.sv
/*
 * Parameterised valid/ready FIFO for converter results.
 * Assumes both sides run on clk_i; reset is synchronous and active low.
 */
`timescale 1ns/1ps
module aopc_fifo #(
	parameter int unsigned W = 12,
	parameter int unsigned D = 8
) (
	input  wire logic         clk_i,     // System clock.
	input  wire logic         rstn_i,    // Synchronous reset, active low.
	input  wire logic         in_vld_i,  // Write request.
	output logic              in_rdy_o,  // Space available.
	input  wire logic [W-1:0] in_dat_i,  // Write data.
	output logic              out_vld_o, // Data available.
	input  wire logic         out_rdy_i, // Reader accepts.
	output logic      [W-1:0] out_dat_o  // Head word.
);
	localparam int unsigned AW = $clog2(D);

	logic [W-1:0]  mem [D];
	logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [AW:0]   cnt_q, cnt_d;
	logic          wr, rd;

	assign in_rdy_o  = (cnt_q != (AW+1)'(D));
	assign out_vld_o = (cnt_q != '0);
	assign out_dat_o = mem[rp_q];
	assign wr        = in_vld_i && in_rdy_o;
	assign rd        = out_vld_o && out_rdy_i;

	always_comb
	begin
		wp_d  = wr ? AW'(wp_q + 1'b1) : wp_q;
		rp_d  = rd ? AW'(rp_q + 1'b1) : rp_q;
		cnt_d = cnt_q;
		if (wr && !rd)
			cnt_d = (AW+1)'(cnt_q + 1'b1);
		else if (rd && !wr)
			cnt_d = (AW+1)'(cnt_q - 1'b1);
	end

	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end
		else
		begin
			wp_q  <= wp_d;
			rp_q  <= rp_d;
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (wr)
			mem[wp_q] <= in_dat_i;
	end

	property p_no_overflow;
		@(posedge clk_i) disable iff (!rstn_i)
		cnt_q <= (AW+1)'(D);
	endproperty
	a_no_overflow: assert property (p_no_overflow) else $error("FIFO count above depth.");

endmodule : aopc_fifo

//--- rtl/aopc_port.sv
/*
 * Output port control of a 12-bit sampling converter: conversion phase timing,
 * format select, output register and three-state result bus.
 * Assumes core samples arrive on the system clock; pins are synchronised here.
 */
`timescale 1ns/1ps
module aopc_port (
	input  wire logic               clk_i,         // System clock, 25 MHz.
	input  wire logic               rstn_i,        // Synchronous reset, active low.
	input  wire logic               oe_n_i,        // Output enable pin, active low.
	input  wire logic               oe_n_pin_en_i, // High when oe pin is connected.
	input  wire logic               msb_invert_select_i, // Format pin, high inverts top bit.
	input  wire logic               fmt_pin_en_i,  // High when format pin is connected.
	input  wire aopc_pkg::aopc_word_t ain_i,       // Core sample value.
	output logic                    sample_window_o, // High while sampling.
	output aopc_pkg::aopc_word_t    result_bus_o,  // Result bus value.
	output logic [11:0]             result_bus_oe_n_o, // Per-bit enable, low drives.
	output logic                    result_vld_o,  // Result strobe toward FIFO.
	output logic                    fifo_ovf_o     // FIFO refused a result.
);
	logic                 oe_s1_q, oe_s2_q, fmt_s1_q, fmt_s2_q;
	logic                 oe_eff, fmt_eff;
	logic [4:0]           div_q, div_d;
	aopc_pkg::aopc_phase_t ph_q, ph_d;
	aopc_pkg::aopc_word_t held_q, held_d;
	aopc_pkg::aopc_word_t pipe_q [aopc_pkg::PIPE_STAGES];
	aopc_pkg::aopc_word_t pipe_d [aopc_pkg::PIPE_STAGES];
	aopc_pkg::aopc_word_t res_q, res_d;
	logic [aopc_pkg::PIPE_STAGES-1:0] fill_q, fill_d;
	logic                 ld_q, ld_d, ovf_q, ovf_d;
	logic                 period_end, hold_edge, in_rdy;
	aopc_pkg::aopc_bus_t  bus;

	function automatic aopc_pkg::aopc_word_t fmt_word(input aopc_pkg::aopc_word_t w,
		input logic inv);
		fmt_word = w;
		fmt_word[aopc_pkg::TOP_BIT] = w[aopc_pkg::TOP_BIT] ^ inv;
	endfunction : fmt_word

	// Pins pass two flip-flops before use.
	always_ff @(posedge clk_i)
	begin
		oe_s1_q  <= oe_n_i;
		oe_s2_q  <= oe_s1_q;
		fmt_s1_q <= msb_invert_select_i;
		fmt_s2_q <= fmt_s1_q;
	end

	assign oe_eff  = oe_n_pin_en_i && oe_s2_q;
	assign fmt_eff = fmt_pin_en_i && fmt_s2_q;

	assign period_end = (div_q == 5'(aopc_pkg::CONV_CYC - 1));
	assign hold_edge  = (ph_q == aopc_pkg::AOPC_SAMPLE) &&
		(div_q == 5'(aopc_pkg::HALF_CYC - 1));

	always_comb
	begin
		div_d  = period_end ? 5'h00 : 5'(div_q + 1'b1);
		ph_d   = ph_q;
		held_d = held_q;
		pipe_d = pipe_q;
		fill_d = fill_q;
		res_d  = res_q;
		ld_d   = 1'b0;
		if (hold_edge)
			ph_d = aopc_pkg::AOPC_HOLD;
		else if (period_end)
			ph_d = aopc_pkg::AOPC_SAMPLE;
		if (hold_edge)
			held_d = ain_i;
		if (period_end)
		begin
			pipe_d[0] = held_q;
			for (int i = 1; i < aopc_pkg::PIPE_STAGES; i++)
				pipe_d[i] = pipe_q[i-1];
			fill_d = {fill_q[aopc_pkg::PIPE_STAGES-2:0], 1'b1};
			if (fill_q[aopc_pkg::PIPE_STAGES-1])
			begin
				res_d = fmt_word(pipe_q[aopc_pkg::PIPE_STAGES-1], fmt_eff);
				ld_d  = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			div_q  <= 5'h00;
			ph_q   <= aopc_pkg::AOPC_SAMPLE;
			held_q <= aopc_pkg::RESULT_RST;
			for (int i = 0; i < aopc_pkg::PIPE_STAGES; i++)
				pipe_q[i] <= aopc_pkg::RESULT_RST;
			fill_q <= '0;
			res_q  <= aopc_pkg::RESULT_RST;
			ld_q   <= 1'b0;
		end
		else
		begin
			div_q  <= div_d;
			ph_q   <= ph_d;
			held_q <= held_d;
			pipe_q <= pipe_d;
			fill_q <= fill_d;
			res_q  <= res_d;
			ld_q   <= ld_d;
		end
	end

	aopc_fifo #(
		.W(aopc_pkg::RES_W),
		.D(aopc_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_i     (clk_i),
		.rstn_i    (rstn_i),
		.in_vld_i  (ld_q),
		.in_rdy_o  (in_rdy),
		.in_dat_i  (res_q),
		.out_vld_o (),
		.out_rdy_i (!oe_eff),
		.out_dat_o ()
	);

	// The FIFO drains only while the bus is enabled; a full FIFO flags a lost result.
	always_comb
	begin
		ovf_d = ovf_q | (ld_q & ~in_rdy);
	end

	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
			ovf_q <= 1'b0;
		else
			ovf_q <= ovf_d;
	end

	assign bus = {res_q, oe_eff};
	assign result_bus_o      = bus.d;
	assign result_bus_oe_n_o = {aopc_pkg::RES_W{bus.oe_n}};
	assign sample_window_o   = (ph_q == aopc_pkg::AOPC_SAMPLE);
	assign result_vld_o      = ld_q;
	assign fifo_ovf_o        = ovf_q;

	property p_release;
		@(posedge clk_i) disable iff (!rstn_i)
		(oe_n_pin_en_i && oe_s2_q) |-> result_bus_oe_n_o == 12'hfff;
	endproperty
	a_release: assert property (p_release) else $error("Bus not released.");

	property p_drive;
		@(posedge clk_i) disable iff (!rstn_i)
		!oe_eff |-> (result_bus_oe_n_o == 12'h000 && result_bus_o == res_q);
	endproperty
	a_drive: assert property (p_drive) else $error("Bus not driven.");

	property p_float;
		@(posedge clk_i) disable iff (!rstn_i)
		(!oe_n_pin_en_i && !fmt_pin_en_i) |-> (!oe_eff && !fmt_eff);
	endproperty
	a_float: assert property (p_float) else $error("Open pin not low.");

	property p_load_hiz;
		@(posedge clk_i) disable iff (!rstn_i)
		(period_end && fill_q[aopc_pkg::PIPE_STAGES-1] && oe_eff) |=> ld_q;
	endproperty
	a_load_hiz: assert property (p_load_hiz) else $error("No load in high Z.");

	property p_window;
		@(posedge clk_i) disable iff (!rstn_i)
		$fell(sample_window_o) |-> ##13 $rose(sample_window_o);
	endproperty
	a_window: assert property (p_window) else $error("Window timing wrong.");

	property p_capture;
		@(posedge clk_i) disable iff (!rstn_i)
		hold_edge |=> held_q == $past(ain_i);
	endproperty
	a_capture: assert property (p_capture) else $error("Wrong sample held.");

	property p_format;
		@(posedge clk_i) disable iff (!rstn_i)
		ld_d |=> (res_q[10:0] == $past(pipe_q[1][10:0])) &&
			(res_q[11] == ($past(pipe_q[1][11]) ^ $past(fmt_eff)));
	endproperty
	a_format: assert property (p_format) else $error("Format wrong.");

	property p_rate;
		@(posedge clk_i) disable iff (!rstn_i)
		ld_q |-> ##25 ld_q;
	endproperty
	a_rate: assert property (p_rate) else $error("Load rate wrong.");

	c_load:   cover property (@(posedge clk_i) disable iff (!rstn_i) ld_q);
	c_hiz:    cover property (@(posedge clk_i) disable iff (!rstn_i) ld_q && oe_eff);
	c_invert: cover property (@(posedge clk_i) disable iff (!rstn_i) ld_q && fmt_eff);
	c_ovf:    cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(fifo_ovf_o));

endmodule : aopc_port

//--- verification/aopc_reader.sv
/*
 * Behavioural model of the system logic that reads the result bus.
 * Assumes the port's clock and its per-bit active-low enables.
 */
`timescale 1ns/1ps
module aopc_reader (
	input  wire logic        clk_i,  // System clock.
	input  wire logic        tie_i,  // High gates oe from the window.
	input  wire logic        oe_n_i, // Bench oe level when not tied.
	input  wire logic        win_i,  // Sample window.
	input  wire logic [11:0] bus_i,  // Port result value.
	input  wire logic [11:0] en_n_i, // Port per-bit enables.
	output logic             oe_n_o, // Oe pin level.
	output logic      [11:0] wire_o, // Resolved line level.
	output logic      [11:0] seen_o  // Last word read while driven.
);
	logic [11:0] last_q = 12'h000;
	assign oe_n_o = tie_i ? win_i : oe_n_i;
	// Released lines show a pattern that changes every cycle.
	assign wire_o = (bus_i & ~en_n_i) | (~last_q & en_n_i);
	always_ff @(posedge clk_i)
	begin
		last_q <= wire_o;
		if (en_n_i == 12'h000)
			seen_o <= wire_o;
	end
endmodule : aopc_reader

//--- verification/adc_output_port_control_test.sv
/*
 * Self-checking bench of the converter output port control.
 * Assumes the port and the reader model; inputs change at falling edges.
 */
`timescale 1ns/1ps
module adc_output_port_control_test;
	logic clk_i = 1'b0, rstn_i = 1'b0, oe_tb = 1'b0, tie = 1'b0, fmt = 1'b0;
	logic oe_pin_en = 1'b1, fmt_pin_en = 1'b1, oe_n, win, vld, ovf;
	logic [11:0] pat = 12'h000, ain = 12'h000, rbus, ren_n, wire_v, seen;
	int fails = 0, comparisons = 0;

	always #20 clk_i = ~clk_i;
	// only the sample phase holds the pattern
	always @(negedge clk_i) ain <= win ? pat : ~pat;

	aopc_port dut (.clk_i(clk_i), .rstn_i(rstn_i), .oe_n_i(oe_n), .oe_n_pin_en_i(oe_pin_en),
		.msb_invert_select_i(fmt), .fmt_pin_en_i(fmt_pin_en), .ain_i(ain),
		.sample_window_o(win), .result_bus_o(rbus), .result_bus_oe_n_o(ren_n),
		.result_vld_o(vld), .fifo_ovf_o(ovf));
	aopc_reader rd (.clk_i(clk_i), .tie_i(tie), .oe_n_i(oe_tb), .win_i(win), .bus_i(rbus),
		.en_n_i(ren_n), .oe_n_o(oe_n), .wire_o(wire_v), .seen_o(seen));

	task tally_and_finish;
	begin
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask : tally_and_finish

	task check(input string n, input logic [11:0] s, input logic [11:0] e);
	begin
		comparisons++;
		if (s !== e)
		begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	end
	endtask : check

	task cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask : cyc

	task next_vld;
		int i;
	begin
		i = 0;
		// The first load after reset needs three full periods of pipeline fill.
		do begin @(negedge clk_i); i++; end while (vld !== 1'b1 && i < 100);
		check("vld wait", {11'h000, vld}, 12'h001);
	end
	endtask : next_vld

	task win_edge(input logic lvl);
		@(negedge clk_i iff win === lvl);
	endtask : win_edge

	task t_release;
	begin
		oe_tb = 1'b1;
		pat = 12'h5a3;
		check("ovf early", {11'h000, ovf}, 12'h000);
		cyc(3);
		check("released", ren_n, 12'hfff);
		repeat (10) next_vld;
		check("load while released", rbus, 12'h5a3);
		check("ovf full", {11'h000, ovf}, 12'h001);
		oe_tb = 1'b0;
		cyc(3);
		check("driven", ren_n, 12'h000);
		check("line", wire_v, 12'h5a3);
		$display("t_release done");
	end
	endtask : t_release

	task t_window;
		int h, l;
	begin
		h = 0;
		l = 0;
		oe_tb = 1'b1;
		win_edge(1'b0);
		win_edge(1'b1);
		while (win === 1'b1) begin h++; @(negedge clk_i); end
		while (win === 1'b0) begin l++; @(negedge clk_i); end
		check("window high", h[11:0], 12'h00c);
		check("window low", l[11:0], 12'h00d);
		next_vld;
		@(negedge clk_i);
		check("vld pulse", {11'h000, vld}, 12'h000);
		h = 1;
		while (vld !== 1'b1 && h < 40) begin h++; @(negedge clk_i); end
		check("vld spacing", h[11:0], 12'h019);
		oe_tb = 1'b0;
		$display("t_window done");
	end
	endtask : t_window

	task t_format;
	begin
		win_edge(1'b0);
		pat = 12'hc35;
		win_edge(1'b1);
		win_edge(1'b0);
		next_vld;
		check("old word", rbus, 12'h5a3);
		repeat (2) next_vld;
		check("binary", rbus, 12'hc35);
		next_vld;
		win_edge(1'b0);
		fmt = 1'b1;
		cyc(2);
		check("no early format", rbus, 12'hc35);
		next_vld;
		check("top inverted", rbus, 12'h435);
		fmt_pin_en = 1'b0;
		repeat (2) next_vld;
		check("format pulled", rbus, 12'hc35);
		fmt_pin_en = 1'b1;
		fmt = 1'b0;
		$display("t_format done");
	end
	endtask : t_format

	task t_pins;
	begin
		oe_pin_en = 1'b0;
		oe_tb = 1'b1;
		cyc(3);
		check("oe pulled", ren_n, 12'h000);
		oe_pin_en = 1'b1;
		oe_tb = 1'b0;
		tie = 1'b1;
		pat = 12'h3e7;
		repeat (3) next_vld;
		win_edge(1'b1);
		cyc(4);
		check("tied release", ren_n, 12'hfff);
		win_edge(1'b0);
		cyc(5);
		check("tied read", seen, 12'h3e7);
		tie = 1'b0;
		$display("t_pins done");
	end
	endtask : t_pins

	// Watchdog sized at about ten times the expected run.
	initial
	begin
		#(8000 * 40);
		fails++;
		tally_and_finish;
	end

	initial
	begin
		cyc(10);
		check("rst bus", rbus, 12'h000);
		check("rst flags", {9'h000, win, vld, ovf}, 12'h004);
		rstn_i = 1'b1;
		t_release;
		t_window;
		t_format;
		t_pins;
		tally_and_finish;
	end
endmodule : adc_output_port_control_test
